// *** design/ssc_pkg.sv ***
// Purpose: constants for the step six sequencer configuration register
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: register offsets are byte addresses of 32-bit words
//
// Notes on behaviour
// (RL1) bit 15 enables step six in the converter sequence; read/write.
// (RL2) bits 14:13 select gain: 00 gives 1, 01 gives 2, 10/11 give 4.
// (RL3) bits 12:5 are reserved and always read zero.
// (RL4) bit 4 picks negative input: 0 analog ground, 1 analog input seven.
// (RL5) bits 3:0 codes 0000 to 0111 pick external inputs zero to seven.
// (RL6) codes 1000, 1001, 1010 pick temperature sensor, internal short, test DAC.
// (RL7) upper codes pick scaled supplies, io supply/4 and analog rail/103 among them.
// (RL8) codes at or above 1000 pick negative input internally; neg bit ignored.
// (RL9) register sits at index 96h, resets to 0006h.
// (RL10) enabled step six converts with current settings; disabled step is skipped.
package ssc_pkg;
  localparam logic [7:0] STEP6_CFG_INDEX = 8'h96;
  localparam logic [11:0] STEP6_CFG_ADDR = {2'h0, STEP6_CFG_INDEX, 2'h0};
  localparam logic [11:0] STATUS_ADDR = 12'h400;
  localparam logic [15:0] STEP6_CFG_RESET = 16'h0006;
  localparam logic [15:0] STEP6_CFG_WMASK = 16'hE01F;
  localparam int EN_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;
  localparam logic [3:0] POS_INTERNAL_FIRST = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] GAIN_X1 = 3'h1;
  localparam logic [2:0] GAIN_X2 = 3'h2;
  localparam logic [2:0] GAIN_X4 = 3'h4;
  typedef enum logic [1:0] {NEG_GROUND, NEG_INPUT_SEVEN, NEG_AUTO} ssc_neg_e;
endpackage : ssc_pkg

// *** design/ssc_route.sv ***
// Purpose: decode step six selections into converter routing controls
// Assumes: inputs come from the configuration register on the same clock
// Notes: outputs are registered
`timescale 1ns/1ps
module ssc_route (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // raw fields
  input wire logic [1:0] gain_code_in,
  input wire logic neg_sel_in,
  input wire logic [3:0] pos_sel_in,
  // decoded routing
  output logic [2:0] gain_factor_out,
  output ssc_pkg::ssc_neg_e neg_route_out,
  output logic internal_src_out
);
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      gain_factor_out <= ssc_pkg::GAIN_X1;
    end else begin
      case (gain_code_in)
        2'h0: gain_factor_out <= ssc_pkg::GAIN_X1; // RL2
        2'h1: gain_factor_out <= ssc_pkg::GAIN_X2; // RL2
        default: gain_factor_out <= ssc_pkg::GAIN_X4; // RL2
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      neg_route_out <= ssc_pkg::NEG_GROUND;
      internal_src_out <= 1'b0;
    end else begin
      // internal and supply codes pick their own negative input
      internal_src_out <= (pos_sel_in >= ssc_pkg::POS_INTERNAL_FIRST); // RL6 RL7
      if (pos_sel_in >= ssc_pkg::POS_INTERNAL_FIRST) begin
        neg_route_out <= ssc_pkg::NEG_AUTO; // RL8
      end else if (neg_sel_in) begin
        neg_route_out <= ssc_pkg::NEG_INPUT_SEVEN; // RL4
      end else begin
        neg_route_out <= ssc_pkg::NEG_GROUND; // RL4
      end
    end
  end
endmodule : ssc_route

// *** design/ssc_step_cfg.sv ***
// Purpose: step six configuration register with AXI4-Lite slave
// Assumes: single clock, synchronous active-low reset
// Notes: status word shows sequencer progress on this step
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module ssc_step_cfg (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // sequencer side
  input wire logic step_six_request_in,
  output logic step_six_convert_out,
  output logic step_six_skip_out,
  // converter controls
  output logic step_six_enable_out,
  output logic [2:0] step_six_gain_out,
  output ssc_pkg::ssc_neg_e step_six_neg_route_out,
  output logic [3:0] step_six_pos_input_out,
  output logic step_six_internal_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] cfg_reg;
  logic [11:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic [15:0] convert_count_reg;
  logic [15:0] skip_count_reg;
  logic do_write;
  logic [15:0] cfg_next;

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture: address and data in either order
  assign s_axi_awready_out = !aw_held_reg && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held_reg && !s_axi_bvalid_out;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_out;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata_in;
      wstrb_reg <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    cfg_next = cfg_reg;
    if (wstrb_reg[0]) begin
      cfg_next[7:0] = wdata_reg[7:0];
    end
    if (wstrb_reg[1]) begin
      cfg_next[15:8] = wdata_reg[15:8];
    end
    // reserved span never stores a one
    cfg_next = cfg_next & ssc_pkg::STEP6_CFG_WMASK; // RL3
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cfg_reg <= ssc_pkg::STEP6_CFG_RESET; // RL9
    end else if (do_write && awaddr_reg == ssc_pkg::STEP6_CFG_ADDR) begin
      cfg_reg <= cfg_next; // RL1 RL2 RL4 RL5
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= ssc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (awaddr_reg == ssc_pkg::STEP6_CFG_ADDR ||
                          awaddr_reg == ssc_pkg::STATUS_ADDR) ?
                         ssc_pkg::RESP_OKAY : ssc_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one outstanding read, address taken only while idle
  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= ssc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= ssc_pkg::RESP_OKAY;
      if (s_axi_araddr_in == ssc_pkg::STEP6_CFG_ADDR) begin
        s_axi_rdata_out <= {16'h0000, cfg_reg}; // RL3
      end else if (s_axi_araddr_in == ssc_pkg::STATUS_ADDR) begin
        s_axi_rdata_out <= {skip_count_reg, convert_count_reg};
      end else begin
        s_axi_rdata_out <= 32'h00000000;
        s_axi_rresp_out <= ssc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer step: convert with current settings or skip
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      step_six_convert_out <= 1'b0;
      step_six_skip_out <= 1'b0;
    end else begin
      step_six_convert_out <= step_six_request_in && cfg_reg[ssc_pkg::EN_BIT]; // RL10
      step_six_skip_out <= step_six_request_in && !cfg_reg[ssc_pkg::EN_BIT]; // RL10
    end
  end

  // counters wrap; software reads them as a rough activity gauge
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      convert_count_reg <= 16'h0000;
      skip_count_reg <= 16'h0000;
    end else begin
      if (step_six_convert_out) begin
        convert_count_reg <= convert_count_reg + 16'h0001;
      end
      if (step_six_skip_out) begin
        skip_count_reg <= skip_count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      step_six_enable_out <= 1'b0;
      step_six_pos_input_out <= 4'h0;
    end else begin
      step_six_enable_out <= cfg_reg[ssc_pkg::EN_BIT]; // RL1
      step_six_pos_input_out <= cfg_reg[ssc_pkg::POS_HI:ssc_pkg::POS_LO]; // RL5
    end
  end

  ssc_route u_route (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .gain_code_in(cfg_reg[ssc_pkg::GAIN_HI:ssc_pkg::GAIN_LO]),
    .neg_sel_in(cfg_reg[ssc_pkg::NEG_BIT]),
    .pos_sel_in(cfg_reg[ssc_pkg::POS_HI:ssc_pkg::POS_LO]),
    .gain_factor_out(step_six_gain_out),
    .neg_route_out(step_six_neg_route_out),
    .internal_src_out(step_six_internal_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  reset_value_a: assert property (@(posedge ref_clk_in) // RL9
    $rose(rst_n_in) |-> cfg_reg == ssc_pkg::STEP6_CFG_RESET)
    else $error("config not at reset value after reset");

  reserved_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL3
    $rose(s_axi_rvalid_out) && $past(s_axi_araddr_in == ssc_pkg::STEP6_CFG_ADDR) |->
    s_axi_rdata_out[12:5] == 8'h00)
    else $error("reserved bits read nonzero");

  enable_follow_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL1
    $past(rst_n_in) |-> step_six_enable_out == $past(cfg_reg[ssc_pkg::EN_BIT]))
    else $error("enable output does not follow register");

  gain_four_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL2
    cfg_reg[14] |=> step_six_gain_out == ssc_pkg::GAIN_X4)
    else $error("gain codes 10 and 11 not four");

  gain_low_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL2
    cfg_reg[14:13] == 2'h1 |=> step_six_gain_out == ssc_pkg::GAIN_X2)
    else $error("gain code 01 not two");

  neg_auto_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL8
    cfg_reg[3] |=> step_six_neg_route_out == ssc_pkg::NEG_AUTO && step_six_internal_out)
    else $error("internal code did not pick negative input itself");

  neg_select_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL4
    !cfg_reg[3] && cfg_reg[4] |=> step_six_neg_route_out == ssc_pkg::NEG_INPUT_SEVEN)
    else $error("negative select not honoured");

  pos_follow_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL5
    $past(rst_n_in) |->
    step_six_pos_input_out == $past(cfg_reg[ssc_pkg::POS_HI:ssc_pkg::POS_LO]))
    else $error("positive input output stale");

  skip_step_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL10
    step_six_request_in && !cfg_reg[ssc_pkg::EN_BIT] |=> step_six_skip_out && !step_six_convert_out)
    else $error("disabled step was not skipped");

  write_stores_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RL1
    do_write && awaddr_reg == ssc_pkg::STEP6_CFG_ADDR && wstrb_reg[1] |=>
    cfg_reg[15] == $past(wdata_reg[15]))
    else $error("write to enable bit not stored");

endmodule : ssc_step_cfg

// *** dv/adc_sequencer_step_config_test.sv ***
// Purpose: self-checking bench for the step six configuration register
// Assumes: AXI4-Lite answer latency unknown, only the timeout ends a wait
// Notes: integer model keeps cfg word and pulse counts
`timescale 1ns/1ps
module adc_sequencer_step_config_test;
  logic ref_clk, rst_n, awv, wv, bready, arv, rready, req;
  logic [11:0] awa, ara;
  logic [31:0] wd, got, seed, d;
  logic [3:0] ws;
  logic [1:0] resp;
  logic [15:0] cfg_m;
  wire logic awr, wr_r, bv, arr, rv, conv, skip, en_o, int_o;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdat;
  wire logic [2:0] gain_o;
  wire logic [3:0] pos_o;
  wire ssc_pkg::ssc_neg_e neg_o;
  int fails, n_tests, cyc, cnv_m, skp_m, nreq;
  ssc_step_cfg dut_u (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_r), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .step_six_request_in(req),
    .step_six_convert_out(conv), .step_six_skip_out(skip),
    .step_six_enable_out(en_o), .step_six_gain_out(gain_o),
    .step_six_neg_route_out(neg_o), .step_six_pos_input_out(pos_o),
    .step_six_internal_out(int_o));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // a hung handshake must still reach the verdict
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t resp got %h exp %h", $time, g, e);
    end
  endtask : chk_resp
  // called just after a rising edge; returns at the edge of the B handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, t1, t2;
    ta = 1'b0;
    tw = 1'b0;
    awa <= a;
    awv <= 1'b1;
    wd <= v;
    ws <= 4'h3;
    wv <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge ref_clk);
      t1 = awv & awr;
      t2 = wv & wr_r;
      @(posedge ref_clk);
      if (t1) begin
        awv <= 1'b0;
        ta = 1'b1;
      end
      if (t2) begin
        wv <= 1'b0;
        tw = 1'b1;
      end
    end
    do @(negedge ref_clk); while (!bv);
    resp = br;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    ara <= a;
    arv <= 1'b1;
    do @(negedge ref_clk); while (!arr);
    @(posedge ref_clk);
    arv <= 1'b0;
    do @(negedge ref_clk); while (!rv);
    got = rdat;
    resp = rr;
    @(posedge ref_clk);
  endtask : rd
  task automatic chk_route;
    chk(en_o, cfg_m[15], "enable");
    chk(gain_o, cfg_m[14:13] == 0 ? 1 : cfg_m[14:13] == 1 ? 2 : 4, "gain");
    chk(pos_o, cfg_m[3:0], "pos");
    chk(neg_o, cfg_m[3] ? 2 : cfg_m[4], "neg");
    chk(int_o, cfg_m[3], "internal");
  endtask : chk_route
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, awv, wv, arv, req, awa, ara, wd, ws} = '0;
    {bready, rready} = 2'h3;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cfg_m = 16'h0006;
    chk_route();
    rd(ssc_pkg::STEP6_CFG_ADDR);
    chk(got, 32'h00000006, "reset");
    $display("test reset done");
    seed = 32'hBF028AF8;
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      d = seed;
      d[3:0] = i[3:0];
      d[15] = i[1];
      wr(ssc_pkg::STEP6_CFG_ADDR, d);
      chk_resp(resp, 2'h0);
      cfg_m = d[15:0] & 16'hE01F;
      rd(ssc_pkg::STEP6_CFG_ADDR);
      chk(got, {16'h0000, cfg_m}, "readback");
      chk_route();
      // odd passes send two requests back to back
      nreq = 1 + i[0];
      req <= 1'b1;
      repeat (nreq) @(posedge ref_clk);
      req <= 1'b0;
      @(negedge ref_clk);
      chk(conv, cfg_m[15], "convert");
      chk(skip, !cfg_m[15], "skip");
      if (cfg_m[15]) cnv_m += nreq;
      else skp_m += nreq;
      @(posedge ref_clk);
    end
    $display("test fields done");
    rd(ssc_pkg::STATUS_ADDR);
    chk(got, {skp_m[15:0], cnv_m[15:0]}, "counts");
    $display("test sequencer done");
    wr(12'h004, 32'h0000FFFF);
    chk_resp(resp, 2'h2);
    rd(12'h004);
    chk_resp(resp, 2'h2);
    chk(got, 32'h0, "unmapped");
    rd(ssc_pkg::STEP6_CFG_ADDR);
    chk(got, {16'h0000, cfg_m}, "unchanged");
    $display("test unmapped done");
    wrap_up();
  end
endmodule : adc_sequencer_step_config_test
